// >>> design/frame_timer.sv
// Free-running frame position counter.
`timescale 1ns/100ps
`default_nettype none
module frame_timer
  import led_pwm_pkg::*;
#(
  parameter int FRAME = FRAME_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  slot_if.timer s
);

  // Position width; the main block sizes the slot bounds the same way.
  localparam int CW = $clog2(FRAME + 1);

  logic [CW-1:0] pos_r; // Current position.
  logic [CW-1:0] pos_nxt; // Next position.

  // Counts from zero to the last cycle of the frame and wraps.
  always_comb begin
    if (pos_r == CW'(FRAME - 1)) begin
      pos_nxt = '0;
    end else begin
      pos_nxt = pos_r + 1'b1;
    end
  end

  // Registers the position.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  assign s.pos = pos_r;

endmodule // frame_timer
`default_nettype wire

// >>> design/led_pwm.sv
// Colour LED PWM control with two byte registers.
// Summary of operation
// - Bit 5 selects switch or sink mode
// - Register PWM needs outputs and PWM enabled
// - Bits 3,2,1 enable red, green, blue
// - Bit 7 enables internal PWM
// - Bit 6 zero turns all colour outputs off
// - Colour bit 0 selects overlapping mode
// - Colour bits 7:4, brightness bits 3:1
// - Brightness doubles per code, zero off
// - Sixteen colour codes give channel shares
// - Colour code ignored in overlapping mode
// - Overlapping drives all channels, duty only
// - Frame fixed; brightness shortens on-times
// - Non-overlapping slots sized by share, brightness
`timescale 1ns/100ps
`default_nettype none
module led_pwm
  import led_pwm_pkg::*;
#(
  parameter int FRAME = FRAME_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic sink_or_switch_select,
  output logic red_sink_pin,
  output logic green_sink_pin,
  output logic blue_sink_pin
);

  localparam int CW = $clog2(FRAME + 1); // Position width.
  localparam int PW = CW + $bits(pct_t); // Product width.
  localparam logic [7:0] RED_FULL_BRIGHT = 8'h0e; // Full red, slots mode.

  // All checks below run on the system clock and sleep during reset.
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ************************************************************
  // Registers.
  // ************************************************************
  logic [7:0] control_r; // Output control register.
  logic [7:0] control_nxt; // Its next value.
  logic [7:0] color_r; // Colour and brightness register.
  logic [7:0] color_nxt; // Its next value.
  logic red_r; // Red pin drive.
  logic green_r; // Green pin drive.
  logic blue_r; // Blue pin drive.
  logic red_nxt; // Next red drive.
  logic green_nxt; // Next green drive.
  logic blue_nxt; // Next blue drive.
  logic [7:0] rdata_r; // Read data flop.
  logic [7:0] rdata_nxt; // Its next value.

  slot_if #(.CW(CW)) sl ();

  // Keeps the frame position.
  frame_timer #(.FRAME(FRAME)) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .s(sl.timer)
  );

  // Write decode; a write to any other address is ignored.
  always_comb begin
    control_nxt = control_r;
    color_nxt = color_r;
    if (reg_wr && reg_addr == OFFS_CONTROL) begin
      control_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == OFFS_COLOR) begin
      color_nxt = reg_wdata;
    end
  end

  // Read mux into the read-data flop; unmapped addresses read zero.
  always_comb begin
    if (reg_addr == OFFS_CONTROL) begin
      rdata_nxt = control_r;
    end else if (reg_addr == OFFS_COLOR) begin
      rdata_nxt = color_r;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  // ************************************************************
  // Slot arithmetic.
  // ************************************************************
  logic [2:0] bright; // Brightness code.
  logic [3:0] color; // Colour code.
  share_t share; // Channel shares.
  logic [CW-1:0] full_on; // Brightness-scaled on-time of the frame.
  logic [PW-1:0] r_len; // Red slot length.
  logic [PW-1:0] g_len; // Green slot length.
  logic [PW-1:0] b_len; // Blue slot length.

  assign bright = color_r[BRIGHT_HI:BRIGHT_LO];
  assign color = color_r[COLOR_HI:COLOR_LO];
  assign share = color_share(color);

  // Code zero is off; each step doubles the fraction up to full.
  always_comb begin
    if (bright == 3'h0) begin
      full_on = '0;
    end else begin
      full_on = CW'(FRAME >> (BRIGHT_SHIFT_MAX - (int'(bright) - 1)));
    end
  end

  // Each slot is its share of the scaled frame, so idle time trails.
  always_comb begin
    r_len = (PW'(full_on) * PW'(share.r)) / PW'(PCT_FULL);
    g_len = (PW'(full_on) * PW'(share.g)) / PW'(PCT_FULL);
    b_len = (PW'(full_on) * PW'(share.b)) / PW'(PCT_FULL);
  end

  // Slots follow red, green, blue from frame start.
  assign sl.r_end = CW'(r_len);
  assign sl.g_end = CW'(r_len + g_len);
  assign sl.b_end = CW'(r_len + g_len + b_len);
  assign sl.on_len = full_on;

  // ************************************************************
  // Pin drive.
  // ************************************************************
  logic run; // Register-defined PWM active.
  logic r_on; // Red wave before enables.
  logic g_on; // Green wave before enables.
  logic b_on; // Blue wave before enables.

  assign run = control_r[BIT_PWM_EN] & control_r[BIT_OUT_EN];

  // Selects the wave: duty only when overlapping, slots otherwise.
  always_comb begin
    if (color_r[BIT_OVERLAP]) begin
      r_on = sl.pos < sl.on_len;
      g_on = sl.pos < sl.on_len;
      b_on = sl.pos < sl.on_len;
    end else begin
      r_on = sl.pos < sl.r_end;
      g_on = sl.pos >= sl.r_end && sl.pos < sl.g_end;
      b_on = sl.pos >= sl.g_end && sl.pos < sl.b_end;
    end
    // Direct on/off when the internal PWM is disabled.
    if (!control_r[BIT_PWM_EN]) begin
      r_on = 1'b1;
      g_on = 1'b1;
      b_on = 1'b1;
    end
    red_nxt = r_on & control_r[BIT_OUT_EN] & control_r[BIT_RED_EN];
    green_nxt = g_on & control_r[BIT_OUT_EN] & control_r[BIT_GREEN_EN];
    blue_nxt = b_on & control_r[BIT_OUT_EN] & control_r[BIT_BLUE_EN];
  end

  // Registers state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_r <= CONTROL_RESET;
      color_r <= COLOR_RESET;
      red_r <= 1'b0;
      green_r <= 1'b0;
      blue_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      control_r <= control_nxt;
      color_r <= color_nxt;
      red_r <= red_nxt;
      green_r <= green_nxt;
      blue_r <= blue_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Read data lags the address by one edge, as it comes from a flop.
  assign reg_rdata = rdata_r;
  assign red_sink_pin = red_r;
  assign green_sink_pin = green_r;
  assign blue_sink_pin = blue_r;
  assign sink_or_switch_select = control_r[BIT_SW_MODE];

  // ************************************************************
  // Checks.
  // ************************************************************
  // All three pins dark.
  sequence s_outs_off;
    !red_sink_pin && !green_sink_pin && !blue_sink_pin;
  endsequence

  // No two pins lit at once.
  sequence s_one_lit;
    !(red_sink_pin && green_sink_pin) && !(green_sink_pin && blue_sink_pin)
      && !(red_sink_pin && blue_sink_pin);
  endsequence

  // All three pins at one level.
  sequence s_pins_alike;
    red_sink_pin == green_sink_pin && green_sink_pin == blue_sink_pin;
  endsequence

  // A control write shows on the mode output at the next edge.
  a_mode_bit_follows: assert property (
    reg_wr && reg_addr == OFFS_CONTROL
      |=> sink_or_switch_select == $past(reg_wdata[BIT_SW_MODE]))
    else $error("drive mode not following control bit");
  a_disabled_outs_off: assert property (
    !control_r[BIT_OUT_EN] |=> s_outs_off)
    else $error("outputs on while disabled");
  a_red_enable_gate: assert property (
    !control_r[BIT_RED_EN] |=> !red_sink_pin)
    else $error("red on while its enable is low");
  a_green_enable_gate: assert property (
    !control_r[BIT_GREEN_EN] |=> !green_sink_pin)
    else $error("green on while its enable is low");
  a_blue_enable_gate: assert property (
    !control_r[BIT_BLUE_EN] |=> !blue_sink_pin)
    else $error("blue on while its enable is low");
  a_zero_bright_off: assert property (
    run && bright == '0 && $stable(color_r) |=> s_outs_off)
    else $error("output on at zero brightness");
  a_slots_exclusive: assert property (
    control_r[BIT_PWM_EN] && !color_r[BIT_OVERLAP] |=> s_one_lit)
    else $error("non-overlapping slots coincide");
  a_overlap_together: assert property (
    run && color_r[BIT_OVERLAP] && control_r[BIT_RED_EN]
      && control_r[BIT_GREEN_EN] && control_r[BIT_BLUE_EN]
      && $stable(color_r) && $stable(control_r) |=> s_pins_alike)
    else $error("overlapping channels differ");
  a_full_red_on: assert property (
    run && control_r[BIT_RED_EN] && color_r == RED_FULL_BRIGHT
      && sl.pos == '0 |=> red_sink_pin)
    else $error("red slot not first");
  a_frame_tail_off: assert property (
    control_r[BIT_PWM_EN] && sl.pos >= sl.b_end && !color_r[BIT_OVERLAP]
      && $stable(color_r) |=> s_outs_off)
    else $error("output on after last slot");

endmodule // led_pwm
`default_nettype wire

// >>> include/led_pwm_pkg.sv
// Package of register layout, timing and colour table for the LED PWM block.
package led_pwm_pkg;

  // ************************************************************
  // Register offsets and field positions.
  // ************************************************************
  localparam logic [7:0] OFFS_CONTROL = 8'h00; // Output control register.
  localparam logic [7:0] OFFS_COLOR = 8'h01; // Colour and brightness register.
  localparam int BIT_PWM_EN = 7; // Internal PWM enable.
  localparam int BIT_OUT_EN = 6; // Colour outputs enable.
  localparam int BIT_SW_MODE = 5; // Sink or switch select.
  localparam int BIT_RED_EN = 3; // Red output enable.
  localparam int BIT_GREEN_EN = 2; // Green output enable.
  localparam int BIT_BLUE_EN = 1; // Blue output enable.
  localparam int BIT_OVERLAP = 0; // Simultaneous drive select.
  localparam int COLOR_HI = 7; // Colour code top bit.
  localparam int COLOR_LO = 4; // Colour code bottom bit.
  localparam int BRIGHT_HI = 3; // Brightness code top bit.
  localparam int BRIGHT_LO = 1; // Brightness code bottom bit.
  localparam logic [7:0] CONTROL_RESET = 8'h20; // Switch mode by default.
  localparam logic [7:0] COLOR_RESET = 8'h00; // Red, zero brightness.

  // ************************************************************
  // Frame timing.
  // ************************************************************
  localparam int FRAME_PERIOD = 50000; // Frame period in nanoseconds.
  localparam int CLK_PERIOD = 4; // Clock period in nanoseconds.
  localparam int FRAME_CYC = FRAME_PERIOD / CLK_PERIOD; // Cycles per frame.
  localparam int PCT_FULL = 100; // Full colour share.
  localparam int BRIGHT_SHIFT_MAX = 6; // Code 001 is 1/64.

  // ************************************************************
  // Colour table: red, green, blue share in percent.
  // ************************************************************
  typedef logic [6:0] pct_t;
  typedef struct packed { pct_t r; pct_t g; pct_t b; } share_t;

  // Returns the per-channel share for a colour code.
  function automatic share_t color_share(input logic [3:0] c);
    share_t s;
    s = '{7'h00, 7'h00, 7'h00};
    case (c)
      4'h0: s = '{7'h64, 7'h00, 7'h00};
      4'h1: s = '{7'h00, 7'h64, 7'h00};
      4'h2: s = '{7'h00, 7'h00, 7'h64};
      4'h3: s = '{7'h32, 7'h32, 7'h00};
      4'h4: s = '{7'h00, 7'h32, 7'h32};
      4'h5: s = '{7'h32, 7'h00, 7'h32};
      4'h6: s = '{7'h21, 7'h21, 7'h21};
      4'h7: s = '{7'h32, 7'h19, 7'h19};
      4'h8: s = '{7'h19, 7'h32, 7'h19};
      4'h9: s = '{7'h19, 7'h32, 7'h19};
      4'ha: s = '{7'h19, 7'h19, 7'h32};
      4'hb: s = '{7'h4b, 7'h19, 7'h00};
      4'hc: s = '{7'h00, 7'h4b, 7'h19};
      4'hd: s = '{7'h19, 7'h4b, 7'h00};
      4'he: s = '{7'h00, 7'h19, 7'h4b};
      default: s = '{7'h19, 7'h00, 7'h4b};
    endcase
    return s;
  endfunction

endpackage

// >>> include/slot_if.sv
// Interface carrying slot bounds from the main block to the slot timer.
`timescale 1ns/100ps
`default_nettype none
interface slot_if #(parameter int CW = 14);
  logic [CW-1:0] r_end; // End of red slot.
  logic [CW-1:0] g_end; // End of green slot.
  logic [CW-1:0] b_end; // End of blue slot.
  logic [CW-1:0] on_len; // Overlapping on-time.
  logic [CW-1:0] pos; // Position in frame.
  modport ctrl (output r_end, g_end, b_end, on_len, input pos);
  modport timer (input r_end, g_end, b_end, on_len, output pos);
endinterface
`default_nettype wire

// >>> sim/led_model.sv
// LED load model that counts lit cycles over one frame.
`timescale 1ns/100ps
`default_nettype none
module led_model #(
  parameter int FRAME = 100
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic red,
  input wire logic green,
  input wire logic blue,
  output logic done,
  output logic [31:0] counts
);
  logic [7:0] n_r, r_r, g_r, b_r, o_r; // Cycle and lit counters.
  logic busy_r; // Measuring a frame.
  logic two; // At least two colours lit together.
  assign two = (red & green) | (red & blue) | (green & blue);
  assign counts = {r_r, g_r, b_r, o_r};
  // Counts the lit cycles of each die over exactly one frame.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {busy_r, done, n_r, r_r, g_r, b_r, o_r} <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        {busy_r, n_r, r_r, g_r, b_r, o_r} <= {1'b1, 40'h0};
      end else if (busy_r) begin
        r_r <= r_r + 8'(red);
        g_r <= g_r + 8'(green);
        b_r <= b_r + 8'(blue);
        o_r <= o_r + 8'(two);
        n_r <= n_r + 8'h01;
        if (n_r == 8'(FRAME - 1)) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // led_model
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking testbench for the colour LED PWM block.
`timescale 1ns/100ps
`default_nettype none
module testbench import led_pwm_pkg::*;;
  localparam int FRAME = 100; // Short frame keeps the run brief.
  logic sys_clk, rst, reg_wr, start, done; // Clock, reset, strobes.
  logic [7:0] reg_addr, reg_wdata, reg_rdata; // Register bus.
  logic sink_or_switch_select; // Output mode seen.
  logic red_sink_pin, green_sink_pin, blue_sink_pin; // LED pins.
  logic [31:0] counts; // Measured lit cycles.
  logic [31:0] exp_q[$]; // Expected measurements, oldest first.
  int failures = 0; // Mismatches seen.
  int checks = 0; // Comparisons made.
  int cycles = 0; // Cycles run, for the hang guard.
  integer seed = 42; // Random seed.
  int rt[16] = '{100,0,0,50,0,50,33,50,25,25,25,75,0,25,0,25}; // Red.
  int gt[16] = '{0,100,0,50,50,0,33,25,50,50,25,25,75,75,25,0}; // Green.
  int bt[16] = '{0,0,100,0,50,50,33,25,25,25,50,0,25,0,75,75}; // Blue.

  led_pwm #(.FRAME(FRAME)) led_pwm_inst (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sink_or_switch_select(sink_or_switch_select),
    .red_sink_pin(red_sink_pin), .green_sink_pin(green_sink_pin),
    .blue_sink_pin(blue_sink_pin));
  led_model #(.FRAME(FRAME)) led_model_inst (.sys_clk(sys_clk), .rst(rst),
    .start(start), .red(red_sink_pin), .green(green_sink_pin),
    .blue(blue_sink_pin), .done(done), .counts(counts));

  // Free-running 250 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One register write, strobe held for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One register read; read data comes from a flop one edge later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    repeat (2) @(posedge sys_clk);
    d = reg_rdata;
  endtask

  // Lit time of one die at a brightness code.
  function automatic int onl(input int b);
    return (b == 0) ? 0 : (FRAME >> (7 - b));
  endfunction

  // Packs red, green, blue and shared lit counts.
  function automatic logic [31:0] pk(input int r, g, b, o);
    return {8'(r), 8'(g), 8'(b), 8'(o)};
  endfunction

  // Programs both registers, notes the expectation, measures a frame.
  task automatic measure(input logic [7:0] c, k, input logic [31:0] e);
    wr(OFFS_CONTROL, c);
    wr(OFFS_COLOR, k);
    repeat (3) @(posedge sys_clk);
    exp_q.push_back(e);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (FRAME + 4) @(posedge sys_clk);
  endtask

  // Takes the oldest note whenever the model finishes a frame.
  always @(posedge sys_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk(counts, 32'hffffffff);
      else chk(counts, exp_q.pop_front());
    end
  end

  // Hang guard, well above the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      stop_test();
    end
  end

  // Main sequence.
  initial begin
    logic [7:0] d;
    int on, b, c, f;
    {rst, reg_wr, start, reg_addr, reg_wdata} = {1'b1, 18'h0};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFFS_CONTROL, d);
    chk(d, CONTROL_RESET);
    rd(OFFS_COLOR, d);
    chk(d, COLOR_RESET);
    rd(8'h05, d);
    chk(d, 8'h00);
    for (c = 0; c < 2; c++) begin
      wr(OFFS_CONTROL, c ? 8'h20 : 8'h00);
      @(posedge sys_clk);
      #1 chk(32'(sink_or_switch_select), c);
    end
    $display("mode test done");
    for (b = 0; b < 8; b++) begin
      c = $random(seed) & 15;
      on = onl(b);
      measure(8'hce, {c[3:0], b[2:0], 1'b1}, pk(on, on, on, on));
    end
    $display("brightness test done");
    for (c = 0; c < 16; c++) begin
      b = (($random(seed) & 32'h7fffffff) % 3) + 5;
      on = onl(b);
      measure(8'hce, {c[3:0], b[2:0], 1'b0}, pk(on * rt[c] / 100,
        on * gt[c] / 100, on * bt[c] / 100, 0));
    end
    measure(8'hce, 8'h0e, pk(FRAME, 0, 0, 0));
    $display("colour test done");
    for (c = 0; c < 8; c++) begin
      f = c[2] + c[1] + c[0];
      measure(8'hc0 | 8'(c << 1), 8'h0f, pk(c[2] * FRAME, c[1] * FRAME,
        c[0] * FRAME, (f > 1) ? FRAME : 0));
    end
    measure(8'h4e, 8'h0f, pk(FRAME, FRAME, FRAME, FRAME));
    measure(8'h8e, 8'h0f, pk(0, 0, 0, 0));
    rd(OFFS_CONTROL, d);
    chk(d, 8'h8e);
    rd(OFFS_COLOR, d);
    chk(d, 8'h0f);
    $display("enable test done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
